// >>> rtl/mdu_defines.svh
// Constants for the modem serial port block.
`ifndef MDU_DEFINES_SVH
`define MDU_DEFINES_SVH
`define MDU_CLK_HZ        10000000
`define MDU_BAUD_DEFAULT  115200
`define MDU_DATA_BITS     8
`define MDU_FIFO_DEPTH    8
`define MDU_LINE_IDLE     1'b1
`define MDU_START_LEVEL   1'b0
`define MDU_STOP_LEVEL    1'b1
`endif

// >>> rtl/mdu_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module mdu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             reset_n,  // Synchronous reset
  input  wire logic [WIDTH-1:0] in_data,  // Write data
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Not full
  output logic      [WIDTH-1:0] out_data, // Read data
  output logic                  out_valid,// Not empty
  input  wire logic             out_ready // Read accept
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (do_rd)
      begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (do_wr && !do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    count <= (AW+1)'(DEPTH))
    else $error("FIFO count exceeds depth");
endmodule // mdu_fifo

// >>> rtl/mdu_pkg.sv
// Types shared by the modem serial port block.
package mdu_pkg;
  typedef enum logic [1:0] {MDU_IDLE, MDU_START, MDU_DATA, MDU_STOP} mdu_state_t;
  // Pin function selector: serial use or general-purpose I/O.
  typedef enum logic {MDU_FN_UART, MDU_FN_GPIO} mdu_fn_t;
endpackage

// >>> rtl/mdu_uart.sv
// Main and auxiliary modem serial ports with modem control lines.
//
// Overview of operation
// R1: Main port has data lines plus carrier, ready, set-ready, RTS, CTS, ring.
// R2: Pins use plain, non-inverted logic; any inversion is external.
// R3: Device drives serial data out on its transmit pin toward the host.
// R4: Device samples host serial data on its receive input pin.
// R5: Carrier-detect output shows whether a carrier is present.
// R6: Host drives terminal-ready; device takes it as host readiness.
// R7: Set-ready output asserts while the module is ready.
// R8: Host request-to-send gates the device transmitter.
// R9: Clear-to-send output tells the host whether it may send.
// R10: Ring-indicator output signals an incoming call.
// R11: Carrier, terminal, set-ready and ring pins may become GPIO by command.
// R12: Terminal-ready held low keeps port and module out of low power.
// R13: Terminal-ready reads high when the pin is left open.
// R14: A host using only data lines must use software flow control.
// R15: Auxiliary port has only transmit and receive data lines.
// R16: Auxiliary pins are shared with SPI; only one function active.
// R17: Frames are start low, data LSB first, stop high.
`timescale 1ns/1ns
`include "mdu_defines.svh"
module mdu_uart #(
  parameter int CLK_HZ = `MDU_CLK_HZ,
  parameter int BAUD   = `MDU_BAUD_DEFAULT,
  parameter int DBITS  = `MDU_DATA_BITS,
  parameter int DEPTH  = `MDU_FIFO_DEPTH
) (
  input  wire logic             clk_sys,          // 10 MHz system clock
  input  wire logic             reset_n,          // Synchronous reset
  input  wire logic [DBITS-1:0] tx_data,          // Byte to send to host
  input  wire logic             tx_valid,         // Byte offered
  output logic                  tx_ready,         // Transmit FIFO has room
  output logic      [DBITS-1:0] rx_data,          // Byte received
  output logic                  rx_valid,         // One-cycle receive pulse
  output logic                  rx_frame_err,     // One-cycle bad stop pulse
  input  wire logic             rx_room,          // User can take data
  input  wire logic             carrier_present,  // Carrier state
  input  wire logic             module_ready,     // Module is ready
  input  wire logic             ring_active,      // Incoming call
  input  wire logic             low_power_req,    // Wish to sleep
  output logic                  low_power_ok,     // Sleep allowed
  output logic                  host_ready,       // Host terminal ready
  input  wire logic [3:0]       gpio_sel,         // Per-pin GPIO select
  input  wire logic [3:0]       gpio_out,         // GPIO output values
  output logic      [3:0]       gpio_in,          // GPIO sampled terminal-ready pin in bit 1, others zero
  input  wire logic             uart_tx_pin_in,   // Unused readback
  output logic                  uart_tx_pin,      // Main transmit pin
  input  wire logic             uart_rx_pin,      // Main receive pin
  output logic                  carrier_detect_out,// Carrier pin
  input  wire logic             dtr_pin_i,        // Terminal-ready pin in
  output logic                  dtr_pin_o,        // Terminal-ready pin out
  output logic                  dtr_pin_oe,       // Terminal-ready drive
  output logic                  dsr_pin,          // Set-ready pin
  input  wire logic             rts_pin,          // Request-to-send pin
  output logic                  cts_pin,          // Clear-to-send pin
  output logic                  ring_indicate_out,// Ring pin
  input  wire logic             spi_select,       // Aux pins owned by SPI
  input  wire logic             spi_mosi,         // SPI master out
  output logic                  spi_miso,         // SPI master in
  input  wire logic [DBITS-1:0] aux_tx_data,      // Aux byte to send
  input  wire logic             aux_tx_valid,     // Aux byte offered
  output logic                  aux_tx_ready,     // Aux transmitter idle
  output logic      [DBITS-1:0] aux_rx_data,      // Aux byte received
  output logic                  aux_rx_valid,     // Aux receive pulse
  output logic                  aux_tx_pin,       // Aux transmit pin
  input  wire logic             aux_rx_pin        // Aux receive pin
);
  localparam int DIV = (CLK_HZ / BAUD) < 1 ? 1 : CLK_HZ / BAUD;
  localparam int CW  = $clog2(DIV + 1);
  localparam int BW  = $clog2(DBITS + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when two and three agree.
  logic [2:0] s_rx, s_dtr, s_rts, s_aux;
  logic       f_rx, f_dtr, f_rts, f_aux;

  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_rx  <= {3{`MDU_LINE_IDLE}};
      s_dtr <= 3'h7;
      s_rts <= 3'h0;
      s_aux <= {3{`MDU_LINE_IDLE}};
      f_rx  <= `MDU_LINE_IDLE;
      f_dtr <= 1'b1;
      f_rts <= 1'b0;
      f_aux <= `MDU_LINE_IDLE;
    end
    else
    begin
      // R4 sample rx
      s_rx  <= {s_rx[1:0], uart_rx_pin};
      s_dtr <= {s_dtr[1:0], dtr_pin_i};
      s_rts <= {s_rts[1:0], rts_pin};
      s_aux <= {s_aux[1:0], aux_rx_pin};
      f_rx  <= filt(s_rx, f_rx);
      f_dtr <= filt(s_dtr, f_dtr);
      f_rts <= filt(s_rts, f_rts);
      f_aux <= filt(s_aux, f_aux);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminal-ready and low power. An open pin is pulled high by the pad.
  // R6 host readiness
  assign host_ready = !gpio_sel[1] && f_dtr;
  // R12 low blocks sleep
  assign low_power_ok = low_power_req && (gpio_sel[1] || f_dtr);
  assign dtr_pin_oe = gpio_sel[1];
  assign dtr_pin_o  = gpio_out[1];
  // R13 floating reads high
  assign gpio_in = {1'b0, 1'b0, f_dtr, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Modem status outputs, registered, non-inverted polarity.
  // R1 R2 R5 R7 R10 R11 status pins
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      carrier_detect_out <= 1'b0;
      dsr_pin            <= 1'b0;
      ring_indicate_out  <= 1'b0;
      cts_pin            <= 1'b0;
    end
    else
    begin
      carrier_detect_out <= gpio_sel[0] ? gpio_out[0] : carrier_present;
      dsr_pin            <= gpio_sel[2] ? gpio_out[2] : module_ready;
      ring_indicate_out  <= gpio_sel[3] ? gpio_out[3] : ring_active;
      // R9 clear to send
      cts_pin            <= rx_room;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO and main transmitter.
  logic [DBITS-1:0] q_data;
  logic             q_valid, q_ready;

  mdu_fifo #(.WIDTH(DBITS), .DEPTH(DEPTH)) u_txq (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .in_data  (tx_data),
    .in_valid (tx_valid),
    .in_ready (tx_ready),
    .out_data (q_data),
    .out_valid(q_valid),
    .out_ready(q_ready)
  );

  mdu_pkg::mdu_state_t tx_st;
  logic [CW-1:0]    tx_cnt;
  logic [BW-1:0]    tx_bit;
  logic [DBITS-1:0] tx_sh;

  // R8 RTS gates start
  assign q_ready = (tx_st == mdu_pkg::MDU_IDLE) && f_rts;

  // R3 R17 transmit framing
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      tx_st       <= mdu_pkg::MDU_IDLE;
      tx_cnt      <= '0;
      tx_bit      <= '0;
      tx_sh       <= '0;
      uart_tx_pin <= `MDU_LINE_IDLE;
    end
    else
    begin
      case (tx_st)
        mdu_pkg::MDU_IDLE:
        begin
          uart_tx_pin <= `MDU_LINE_IDLE;
          if (q_valid && q_ready)
          begin
            tx_sh       <= q_data;
            tx_cnt      <= CW'(DIV - 1);
            uart_tx_pin <= `MDU_START_LEVEL;
            tx_st       <= mdu_pkg::MDU_START;
          end
        end
        default:
        begin
          if (tx_cnt != '0)
          begin
            tx_cnt <= tx_cnt - 1'b1;
          end
          else
          begin
            tx_cnt <= CW'(DIV - 1);
            if (tx_st == mdu_pkg::MDU_STOP)
            begin
              tx_st       <= mdu_pkg::MDU_IDLE;
              uart_tx_pin <= `MDU_LINE_IDLE;
            end
            else if (tx_st == mdu_pkg::MDU_START || tx_bit != BW'(DBITS))
            begin
              uart_tx_pin <= tx_sh[0];
              tx_sh       <= tx_sh >> 1;
              tx_bit      <= tx_bit + 1'b1;
              tx_st       <= mdu_pkg::MDU_DATA;
            end
            else
            begin
              uart_tx_pin <= `MDU_STOP_LEVEL;
              tx_bit      <= '0;
              tx_st       <= mdu_pkg::MDU_STOP;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main receiver: centre-sampled, frame error on a low stop bit.
  mdu_pkg::mdu_state_t rx_st;
  logic [CW-1:0]    rx_cnt;
  logic [BW-1:0]    rx_bit;
  logic [DBITS-1:0] rx_sh;

  // R4 R17 receive framing
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rx_st        <= mdu_pkg::MDU_IDLE;
      rx_cnt       <= '0;
      rx_bit       <= '0;
      rx_sh        <= '0;
      rx_data      <= '0;
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
    end
    else
    begin
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
      case (rx_st)
        mdu_pkg::MDU_IDLE:
        begin
          if (f_rx == `MDU_START_LEVEL)
          begin
            rx_cnt <= CW'(DIV / 2);
            rx_st  <= mdu_pkg::MDU_START;
          end
        end
        default:
        begin
          if (rx_cnt != '0)
          begin
            rx_cnt <= rx_cnt - 1'b1;
          end
          else
          begin
            rx_cnt <= CW'(DIV - 1);
            if (rx_st == mdu_pkg::MDU_START)
            begin
              // A start bit shorter than half a bit is a glitch.
              rx_st <= (f_rx == `MDU_START_LEVEL) ? mdu_pkg::MDU_DATA
                                                  : mdu_pkg::MDU_IDLE;
              rx_bit <= '0;
            end
            else if (rx_st == mdu_pkg::MDU_DATA)
            begin
              rx_sh  <= {f_rx, rx_sh[DBITS-1:1]};
              rx_bit <= rx_bit + 1'b1;
              if (rx_bit == BW'(DBITS - 1))
              begin
                rx_st <= mdu_pkg::MDU_STOP;
              end
            end
            else
            begin
              rx_st <= mdu_pkg::MDU_IDLE;
              if (f_rx == `MDU_STOP_LEVEL)
              begin
                rx_data  <= rx_sh;
                rx_valid <= 1'b1;
              end
              else
              begin
                rx_frame_err <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary port: data lines only, pins shared with the SPI master.
  // Built as a second small transmit/receive pair sharing the bit timing.
  logic [CW-1:0]      ax_cnt;
  logic [BW+1:0]      ax_bit;
  logic [DBITS+1:0]   ax_sh;
  logic               ax_uart_tx;
  logic [CW-1:0]      ar_cnt;
  logic [BW+1:0]      ar_bit;
  logic [DBITS:0]     ar_sh;
  logic               aux_rx_in;

  // R15 R16 pin sharing
  assign aux_tx_pin   = spi_select ? spi_mosi : ax_uart_tx;
  assign spi_miso     = spi_select ? aux_rx_pin : 1'b0;
  assign aux_rx_in    = spi_select ? `MDU_LINE_IDLE : f_aux;
  assign aux_tx_ready = !spi_select && (ax_bit == '0) && (ax_cnt == '0);

  // R17 aux transmit
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ax_cnt     <= '0;
      ax_bit     <= '0;
      ax_sh      <= '1;
      ax_uart_tx <= `MDU_LINE_IDLE;
    end
    // The stop bit runs its full count before the next start is taken.
    else if (ax_cnt != '0)
    begin
      ax_cnt <= ax_cnt - 1'b1;
    end
    else if (ax_bit == '0)
    begin
      ax_uart_tx <= `MDU_LINE_IDLE;
      if (aux_tx_valid && aux_tx_ready)
      begin
        ax_sh  <= {`MDU_STOP_LEVEL, aux_tx_data, `MDU_START_LEVEL};
        ax_bit <= (BW+2)'(DBITS + 2);
        ax_cnt <= '0;
      end
    end
    else
    begin
      ax_uart_tx <= ax_sh[0];
      ax_sh      <= {1'b1, ax_sh[DBITS+1:1]};
      ax_bit     <= ax_bit - 1'b1;
      ax_cnt     <= CW'(DIV - 1);
    end
  end

  // R17 aux receive
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ar_cnt       <= '0;
      ar_bit       <= '0;
      ar_sh        <= '0;
      aux_rx_data  <= '0;
      aux_rx_valid <= 1'b0;
    end
    else
    begin
      aux_rx_valid <= 1'b0;
      if (ar_bit == '0)
      begin
        if (aux_rx_in == `MDU_START_LEVEL)
        begin
          ar_cnt <= CW'(DIV / 2);
          ar_bit <= (BW+2)'(DBITS + 2);
        end
      end
      else if (ar_cnt != '0)
      begin
        ar_cnt <= ar_cnt - 1'b1;
      end
      else
      begin
        ar_cnt <= CW'(DIV - 1);
        ar_bit <= ar_bit - 1'b1;
        if (ar_bit != (BW+2)'(DBITS + 2))
        begin
          ar_sh <= {aux_rx_in, ar_sh[DBITS:1]};
        end
        if (ar_bit == (BW+2)'(1) && aux_rx_in == `MDU_STOP_LEVEL)
        begin
          aux_rx_data  <= ar_sh[DBITS:1];
          aux_rx_valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence tx_begin_s;
    (tx_st == mdu_pkg::MDU_IDLE) && q_valid && q_ready;
  endsequence

  tx_start_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tx_begin_s |=> !uart_tx_pin) // R17
    else $error("Start bit not low");
  rts_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (tx_st == mdu_pkg::MDU_IDLE) && !f_rts |=> tx_st == mdu_pkg::MDU_IDLE) // R8
    else $error("Transmit began without RTS");
  tx_idle_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(tx_st) == mdu_pkg::MDU_IDLE && tx_st == mdu_pkg::MDU_IDLE
      |-> uart_tx_pin) // R3
    else $error("Idle transmit line not high");
  cts_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cts_pin == $past(rx_room)) // R9
    else $error("CTS does not follow room");
  dtr_sleep_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !gpio_sel[1] && !f_dtr |-> !low_power_ok) // R12
    else $error("Sleep allowed with terminal-ready low");
  dcd_mirror_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !$past(gpio_sel[0]) |-> carrier_detect_out == $past(carrier_present)) // R5
    else $error("Carrier output mismatch");
  ring_mirror_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !$past(gpio_sel[3]) |-> ring_indicate_out == $past(ring_active)) // R10
    else $error("Ring output mismatch");
  dsr_gpio_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(gpio_sel[2]) |-> dsr_pin == $past(gpio_out[2])) // R11
    else $error("Set-ready GPIO mismatch");
  aux_share_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    spi_select |-> aux_tx_pin == spi_mosi && !aux_tx_ready) // R16
    else $error("Aux pin not handed to SPI");
endmodule // mdu_uart

// >>> tb/mdu_host_model.sv
// Behavioural host UART facing the modem main and auxiliary ports.
`timescale 1ns/1ns
module mdu_host_model #(
  parameter int DIV = 10
) (
  input  wire logic clk_sys,      // Clock used for bit timing
  input  wire logic dev_txd,      // Device main transmit pin
  input  wire logic aux_txd,      // Device auxiliary transmit pin
  output logic      host_txd,     // Host transmit toward main port
  output logic      aux_host_txd, // Host transmit toward aux port
  output logic      rts_pin,      // Request-to-send toward device
  output logic      dtr_drive,    // Host actively drives terminal-ready
  output logic      dtr_level     // Terminal-ready level when driven
);
  initial
  begin
    host_txd = 1'b1;
    aux_host_txd = 1'b1;
    rts_pin = 1'b0;
    dtr_drive = 1'b0;
    dtr_level = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // host gates the device transmitter with request-to-send.
  task automatic set_rts(input logic v);
    @(posedge clk_sys);
    rts_pin <= v;
  endtask

  // host signals readiness, or releases the pin to its pull-up.
  task automatic set_dtr(input logic drv, input logic lvl);
    @(posedge clk_sys);
    dtr_drive <= drv;
    dtr_level <= lvl;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // software paced sending.
  // start low, data LSB first, stop, then at least one idle bit.
  task automatic send(input logic aux, input logic [7:0] b,
                      input logic stp);
    logic [10:0] fr;
    fr = {1'b1, stp, b, 1'b0};
    for (int k = 0; k < 11; k++)
    begin
      @(posedge clk_sys);
      if (aux)
        aux_host_txd <= fr[k];
      else
        host_txd <= fr[k];
      repeat (DIV - 1) @(posedge clk_sys);
    end
  endtask

  // sample mid-bit; a missing start bit times out after 3000 cycles and the idle line reads as ones.
  task automatic capture(input logic aux, output logic [7:0] b,
                         output logic stp);
    int n;
    n = 0;
    b = 8'h00;
    stp = 1'b0;
    while ((aux ? aux_txd : dev_txd) !== 1'b0 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    repeat (DIV / 2) @(posedge clk_sys);
    for (int k = 0; k < 8; k++)
    begin
      repeat (DIV) @(posedge clk_sys);
      b[k] = aux ? aux_txd : dev_txd;
    end
    repeat (DIV) @(posedge clk_sys);
    stp = aux ? aux_txd : dev_txd;
  endtask
endmodule // mdu_host_model

// >>> tb/testbench.sv
// Self-checking testbench for the modem serial port block.
`timescale 1ns/1ns
module testbench;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] tx_data, rx_data, aux_tx_data, aux_rx_data;
  logic       tx_valid, tx_ready, rx_valid, rx_frame_err, rx_room;
  logic       carrier_present, module_ready, ring_active;
  logic       low_power_req, low_power_ok, host_ready;
  logic [3:0] gpio_sel, gpio_out, gpio_in;
  logic       uart_tx_pin, uart_rx_pin, carrier_detect_out;
  logic       dtr_pin_o, dtr_pin_oe, dsr_pin, rts_pin, cts_pin;
  logic       ring_indicate_out, spi_select, spi_mosi, spi_miso;
  logic       aux_tx_valid, aux_tx_ready, aux_rx_valid;
  logic       aux_tx_pin, aux_rx_pin, aux_host_txd, slave_bit;
  logic       dtr_drive, dtr_level, dtr_line;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cycles = 0;

  always #50 clk_sys = ~clk_sys;
  // The terminal-ready pin floats high when nobody drives it.
  assign dtr_line = dtr_pin_oe ? dtr_pin_o : (dtr_drive ? dtr_level : 1'b1);
  assign aux_rx_pin = spi_select ? slave_bit : aux_host_txd;

  mdu_uart #(.BAUD(1000000)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_frame_err(rx_frame_err), .rx_room(rx_room),
    .carrier_present(carrier_present), .module_ready(module_ready),
    .ring_active(ring_active), .low_power_req(low_power_req),
    .low_power_ok(low_power_ok), .host_ready(host_ready),
    .gpio_sel(gpio_sel), .gpio_out(gpio_out), .gpio_in(gpio_in),
    .uart_tx_pin_in(uart_tx_pin), .uart_tx_pin(uart_tx_pin),
    .uart_rx_pin(uart_rx_pin), .carrier_detect_out(carrier_detect_out),
    .dtr_pin_i(dtr_line), .dtr_pin_o(dtr_pin_o), .dtr_pin_oe(dtr_pin_oe),
    .dsr_pin(dsr_pin), .rts_pin(rts_pin), .cts_pin(cts_pin),
    .ring_indicate_out(ring_indicate_out), .spi_select(spi_select),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .aux_tx_data(aux_tx_data),
    .aux_tx_valid(aux_tx_valid), .aux_tx_ready(aux_tx_ready),
    .aux_rx_data(aux_rx_data), .aux_rx_valid(aux_rx_valid),
    .aux_tx_pin(aux_tx_pin), .aux_rx_pin(aux_rx_pin));

  mdu_host_model #(.DIV(10)) host (
    .clk_sys(clk_sys), .dev_txd(uart_tx_pin), .aux_txd(aux_tx_pin),
    .host_txd(uart_rx_pin), .aux_host_txd(aux_host_txd),
    .rts_pin(rts_pin), .dtr_drive(dtr_drive), .dtr_level(dtr_level));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A hang in any wait loop ends here rather than running forever.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Waits for a main or aux receive pulse; err notes a bad stop bit on the main port only.
  task automatic wait_rx(input logic aux, output logic seen,
                         output logic [7:0] d, output logic err);
    seen = 1'b0;
    d = 8'h00;
    err = 1'b0;
    for (int i = 0; i < 150 && !seen; i++)
    begin
      @(negedge clk_sys);
      seen = aux ? aux_rx_valid === 1'b1
                 : (rx_valid === 1'b1 || rx_frame_err === 1'b1);
      d = aux ? aux_rx_data : rx_data;
      err = rx_frame_err;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge clk_sys);
    chk(uart_tx_pin, 1'b1);
    chk({ring_indicate_out, cts_pin, dsr_pin, carrier_detect_out}, 0);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    $display("t_reset done");
  endtask

  // One-hot patterns, then all zero, catch swapped or stuck control outputs.
  task automatic t_lines();
    logic [3:0] p;
    for (int i = 0; i < 5; i++)
    begin
      p = 4'h1 << i;
      @(posedge clk_sys);
      {ring_active, rx_room, module_ready, carrier_present} <= p;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({ring_indicate_out, cts_pin, dsr_pin, carrier_detect_out}, p);
    end
    $display("t_lines done");
  endtask

  task automatic t_fill();
    int n;
    logic held;
    logic [7:0] b;
    logic s;
    n = 0;
    held = 1'b0;
    host.set_rts(1'b0);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_sys);
      tx_valid <= 1'b1;
      tx_data <= 8'h30 + 8'(n);
      @(negedge clk_sys);
      if (tx_ready !== 1'b1)
        break;
      n++;
    end
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    chk(8'(n), 8'h08);
    repeat (40)
    begin
      @(negedge clk_sys);
      held = held | (uart_tx_pin !== 1'b1);
    end
    chk(held, 1'b0);
    host.set_rts(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      host.capture(1'b0, b, s);
      chk(b, 8'h30 + 8'(i));
      chk(s, 1'b1);
    end
    $display("t_fill done");
  endtask

  task automatic t_rx();
    logic seen;
    logic [7:0] d;
    logic e;
    fork
      host.send(1'b0, 8'hA5, 1'b1);
      wait_rx(1'b0, seen, d, e);
    join
    chk({seen, e}, 2'b10);
    chk(d, 8'hA5);
    fork
      host.send(1'b0, 8'h3C, 1'b0);
      wait_rx(1'b0, seen, d, e);
    join
    chk({seen, e}, 2'b11);
    $display("t_rx done");
  endtask

  task automatic t_dtr();
    low_power_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({host_ready, low_power_ok}, 2'b11);
    host.set_dtr(1'b1, 1'b0);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({host_ready, low_power_ok}, 2'b00);
    host.set_dtr(1'b0, 1'b1);
    gpio_sel <= 4'b1111;
    gpio_out <= 4'b1101;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({dtr_pin_oe, dtr_pin_o, low_power_ok, host_ready}, 4'hA);
    chk({ring_indicate_out, dsr_pin, carrier_detect_out}, 3'b111);
    chk(gpio_in, 4'h0);
    gpio_out <= 4'b0010;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(gpio_in, 4'h2);
    chk({ring_indicate_out, dsr_pin, carrier_detect_out}, 3'b000);
    gpio_sel <= 4'h0;
    low_power_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(low_power_ok, 1'b0);
    $display("t_dtr done");
  endtask

  task automatic t_aux();
    logic [7:0] b;
    logic s;
    logic seen;
    logic e;
    fork
      begin
        @(posedge clk_sys);
        aux_tx_data <= 8'h96;
        aux_tx_valid <= 1'b1;
        for (int i = 0; i < 50 && aux_tx_ready !== 1'b1; i++)
          @(negedge clk_sys);
        @(posedge clk_sys);
        aux_tx_valid <= 1'b0;
      end
      host.capture(1'b1, b, s);
    join
    chk(b, 8'h96);
    chk(s, 1'b1);
    fork
      host.send(1'b1, 8'h5A, 1'b1);
      wait_rx(1'b1, seen, b, e);
    join
    chk(b, 8'h5A);
    chk(seen, 1'b1);
    spi_select <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk_sys);
      spi_mosi <= v[0];
      slave_bit <= ~v[0];
      @(negedge clk_sys);
      chk({aux_tx_ready, aux_tx_pin, spi_miso}, {1'b0, v[0], ~v[0]});
    end
    $display("t_aux done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {tx_data, aux_tx_data, gpio_sel, gpio_out} = 24'h0;
    {tx_valid, rx_room, carrier_present, module_ready} = 4'h0;
    {ring_active, low_power_req, spi_select, spi_mosi} = 4'h0;
    {aux_tx_valid, slave_bit} = 2'b00;
    repeat (10) @(posedge clk_sys);
    t_reset();
    t_lines();
    t_fill();
    t_rx();
    t_dtr();
    t_aux();
    print_verdict();
  end
endmodule // testbench
